/* src/pslr_pkg.sv */
// Purpose: Shared constants for the rail ramp, regulator code and
//          sequencer gap register block
// Assumes: 50 MHz system clock
// Notes:   Times are kept in their own units, cycle counts derive from them
package pslr_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;

    // Register offsets
    localparam logic [7:0] ADDR_RAMP_CTRL = 8'h1a;
    localparam logic [7:0] ADDR_LINREG    = 8'h1b;
    localparam logic [7:0] ADDR_SEQ_GAPS  = 8'h20;

    // Reset values
    localparam logic [7:0] RST_RAMP_CTRL = 8'h06;
    localparam logic [7:0] RST_LINREG    = 8'h1f;
    localparam logic [7:0] RST_SEQ_GAPS  = 8'h00;

    // Ramp control fields
    localparam int unsigned BIT_TRIGGER    = 7;
    localparam int unsigned BIT_AUTO_APPLY = 6;
    localparam int unsigned RATE_LSB       = 0;
    localparam int unsigned RATE_W         = 3;
    localparam logic [2:0]  RATE_FASTEST   = 3'h6;
    localparam logic [2:0]  RATE_IMMEDIATE = 3'h7;

    // Linear regulator code field and voltage map
    localparam int unsigned LINREG_LSB     = 0;
    localparam int unsigned LINREG_W       = 6;
    localparam logic [5:0]  LINREG_KNEE    = 6'h1a;
    localparam logic [11:0] LINREG_BASE_MV = 12'h384;
    localparam logic [11:0] LINREG_KNEE_MV = 12'h60e;
    localparam logic [11:0] LINREG_FINE_MV = 12'h019;
    localparam logic [11:0] LINREG_COARSE_MV = 12'h032;

    localparam int unsigned SETPOINT_W = 6;
    localparam int unsigned NUM_RAILS  = 2;
    localparam int unsigned CNT_W      = 20;

    // Timing
    localparam int unsigned DWELL_MIN_NS = 2500;
    localparam int unsigned DWELL_BASE_CYC =
        (DWELL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_MS = 5;
    localparam int unsigned BLANK_CYC =
        (BLANK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_SHORT_MS = 2;
    localparam int unsigned GAP_LONG_MS  = 5;
    localparam int unsigned GAP_SHORT_CYC =
        (GAP_SHORT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_LONG_CYC =
        (GAP_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic
    {
        PSLR_IDLE = 1'b0,
        PSLR_WAIT = 1'b1
    } pslr_state_e;

endpackage

/* src/pslr_ramp_if.sv */
// Purpose: Carries one rail's ramp command and state between modules
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
interface pslr_ramp_if;
    logic                                 start;
    logic                                 immediate;
    logic [pslr_pkg::SETPOINT_W-1:0]      start_code;
    logic [pslr_pkg::CNT_W-1:0]           dwell;
    logic [pslr_pkg::SETPOINT_W-1:0]      applied;
    logic                                 busy;

    modport ctrl (output start, immediate, start_code, dwell,
                  input applied, busy);
    modport ramp (input start, immediate, start_code, dwell,
                  output applied, busy);
endinterface

/* src/pslr_ramp.sv */
// Purpose: Steps one buck rail's applied code toward its target
// Assumes: dwell is at least one cycle
// Notes:   A new start retargets a ramp already under way
`timescale 1ns/1ps
module pslr_ramp
#(
    parameter logic [pslr_pkg::SETPOINT_W-1:0] INIT_CODE = 6'h00
)
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Command and state
    pslr_ramp_if.ramp      port
);

    pslr_pkg::pslr_state_e                state;
    pslr_pkg::pslr_state_e                next_state;
    logic [pslr_pkg::SETPOINT_W-1:0]      target;
    logic [pslr_pkg::SETPOINT_W-1:0]      next_target;
    logic [pslr_pkg::SETPOINT_W-1:0]      applied;
    logic [pslr_pkg::SETPOINT_W-1:0]      next_applied;
    logic [pslr_pkg::CNT_W-1:0]           cnt;
    logic [pslr_pkg::CNT_W-1:0]           next_cnt;
    logic [pslr_pkg::SETPOINT_W-1:0]      stepped;

    always_comb
    begin
        next_state   = state;
        next_target  = target;
        next_applied = applied;
        next_cnt     = cnt;
        stepped      = (applied < target) ? applied + 6'h01
                                          : applied - 6'h01;
        if (port.start)
        begin
            next_target = port.start_code;
            if (port.immediate)
            begin
                next_applied = port.start_code;  // see [R5]
                next_state   = pslr_pkg::PSLR_IDLE;
            end
            else if (port.start_code != applied)
            begin
                next_state = pslr_pkg::PSLR_WAIT;
                next_cnt   = port.dwell - 20'h00001;
            end
            else
            begin
                next_state = pslr_pkg::PSLR_IDLE;
            end
        end
        else
        begin
            case (state)
                pslr_pkg::PSLR_IDLE:
                begin
                    next_cnt = '0;
                end
                pslr_pkg::PSLR_WAIT:
                begin
                    // One code per dwell, so ramp rate follows code size
                    if (cnt == '0)
                    begin
                        next_applied = stepped;  // see [R13] see [R6]
                        if (stepped == target)
                        begin
                            next_state = pslr_pkg::PSLR_IDLE;
                        end
                        else
                        begin
                            next_cnt = port.dwell - 20'h00001;
                        end
                    end
                    else
                    begin
                        next_cnt = cnt - 20'h00001;
                    end
                end
                default:
                begin
                    next_state = pslr_pkg::PSLR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state   <= pslr_pkg::PSLR_IDLE;
            target  <= INIT_CODE;
            applied <= INIT_CODE;
            cnt     <= '0;
        end
        else
        begin
            state   <= next_state;
            target  <= next_target;
            applied <= next_applied;
            cnt     <= next_cnt;
        end
    end

    assign port.applied = applied;
    assign port.busy    = (state == pslr_pkg::PSLR_WAIT);  // see [R13]

endmodule

/* src/pslr_top.sv */
// Purpose: Ramp control, linear regulator code and first sequencer gap
//          register, with the ramp engines of the two main buck rails
// Assumes: Register port is the decoded side of the serial interface;
//          unlock comes from the password logic on the same clock
// Notes:   Buck setpoint registers live outside; their values and write
//          pulses come in on ports
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Writing one to the trigger starts both buck rails toward stored codes.
// [R2] Trigger clears itself when both rails finish; reads one while ramping.
// [R3] Auto-apply starts a rail ramp on each setpoint write, no trigger.
// [R4] Rate codes 0-6 give 160 down to 2.5 us per code step.
// [R5] Rate code seven applies the new code at once.
// [R6] Dwell applies per code step, so rate scales with step size.
// [R7] Host unlocks first; locked writes to regulator and gap regs ignored.
// [R8] Any regulator code write blanks its voltage monitors for 5 ms; here a locked write is dropped and does not blank.
// [R9] Regulator code maps 0.9 V in 25 mV, then 50 mV steps to 3.4 V.
// [R10] Gap bit n selects 2 ms or 5 ms after slot n.
// [R11] Gap after slot one at bit zero, slot eight at bit seven; reset zero.
// [R12] Ramp logic serves only the two main buck rails.
// [R13] Rails step one code per dwell and finish when applied meets target.
module pslr_top
#(
    parameter int unsigned DWELL_BASE_CYC = pslr_pkg::DWELL_BASE_CYC,
    parameter int unsigned BLANK_CYC      = pslr_pkg::BLANK_CYC,
    parameter int unsigned GAP_SHORT_CYC  = pslr_pkg::GAP_SHORT_CYC,
    parameter int unsigned GAP_LONG_CYC   = pslr_pkg::GAP_LONG_CYC
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        unlock_ok,
    // Buck rail setpoints
    input  wire logic [5:0]  buck_rail_a_setpoint,
    input  wire logic [5:0]  buck_rail_b_setpoint,
    input  wire logic        buck_rail_a_wr,
    input  wire logic        buck_rail_b_wr,
    // Buck rail applied codes
    output logic      [5:0]  buck_rail_a_applied,
    output logic      [5:0]  buck_rail_b_applied,
    output logic             ramp_busy,
    // Linear regulator
    output logic      [5:0]  linear_reg_setpoint,
    output logic      [11:0] linear_reg_mv,
    output logic             monitor_blank,
    // Sequencer gaps
    output logic      [7:0]  sequencer_gap_reg,
    input  wire logic [2:0]  gap_query_slot,
    output logic      [17:0] gap_query_cycles
);

    // Per-rate dwell; doubling per code keeps it a shift of the base
    function automatic logic [pslr_pkg::CNT_W-1:0] dwell_of
    (
        input logic [2:0] rate
    );
        logic [pslr_pkg::CNT_W-1:0] base;
        base = pslr_pkg::CNT_W'(DWELL_BASE_CYC);
        dwell_of = base << (pslr_pkg::RATE_FASTEST - rate);  // see [R4]
    endfunction

    function automatic logic [11:0] mv_of
    (
        input logic [5:0] code
    );
        logic [11:0] c;
        c = {6'h00, code};
        if (code <= pslr_pkg::LINREG_KNEE)
        begin
            mv_of = 12'(pslr_pkg::LINREG_BASE_MV
                        + c * pslr_pkg::LINREG_FINE_MV);
        end
        else
        begin
            mv_of = 12'(pslr_pkg::LINREG_KNEE_MV
                        + (c - {6'h00, pslr_pkg::LINREG_KNEE})
                        * pslr_pkg::LINREG_COARSE_MV);
        end
    endfunction

    logic        trigger;
    logic        next_trigger;
    logic        auto_apply;
    logic        next_auto_apply;
    logic [2:0]  rate;
    logic [2:0]  next_rate;
    logic [5:0]  linreg;
    logic [5:0]  next_linreg;
    logic [7:0]  gaps;
    logic [7:0]  next_gaps;
    logic [17:0] blank_cnt;
    logic [17:0] next_blank_cnt;
    logic [7:0]  rdata;
    logic [7:0]  next_rdata;
    logic [11:0] mv;
    logic [11:0] next_mv;
    logic [17:0] gap_cyc;
    logic [17:0] next_gap_cyc;

    logic        wr_ctrl;
    logic        wr_linreg;
    logic        wr_gaps;
    logic        go_pulse;
    logic        just_started;
    logic [2:0]  eff_rate;
    logic [1:0]  rail_wr;
    logic [1:0]  rail_busy;
    logic [5:0]  rail_sp [pslr_pkg::NUM_RAILS];
    logic [5:0]  rail_app [pslr_pkg::NUM_RAILS];

    assign wr_ctrl   = reg_wr_en && (reg_addr == pslr_pkg::ADDR_RAMP_CTRL);
    // Locked writes are dropped here and never reach the register
    assign wr_linreg = reg_wr_en && unlock_ok
                       && (reg_addr == pslr_pkg::ADDR_LINREG);   // see [R7]
    assign wr_gaps   = reg_wr_en && unlock_ok
                       && (reg_addr == pslr_pkg::ADDR_SEQ_GAPS); // see [R7]
    assign go_pulse  = wr_ctrl && reg_wdata[pslr_pkg::BIT_TRIGGER]; // see [R1]
    assign rail_wr   = {buck_rail_b_wr, buck_rail_a_wr};
    assign rail_sp[0] = buck_rail_a_setpoint;
    assign rail_sp[1] = buck_rail_b_setpoint;
    // A trigger write ramps at the rate it carries, not the stale one
    assign eff_rate  = wr_ctrl ? reg_wdata[pslr_pkg::RATE_LSB +:
                                           pslr_pkg::RATE_W] : rate; // see [R1]

    // Only the two main buck rails have ramp engines
    pslr_ramp_if rif [pslr_pkg::NUM_RAILS] ();  // see [R12]

    genvar g;
    generate
        for (g = 0; g < pslr_pkg::NUM_RAILS; g++)
        begin : g_rail
            assign rif[g].start      = go_pulse
                                       || (auto_apply && rail_wr[g]); // see [R3]
            assign rif[g].immediate  = (eff_rate == pslr_pkg::RATE_IMMEDIATE);
            assign rif[g].start_code = rail_sp[g];
            assign rif[g].dwell      = dwell_of(eff_rate);
            assign rail_busy[g]      = rif[g].busy;
            assign rail_app[g]       = rif[g].applied;

            pslr_ramp u_ramp
            (
                .clk  (clk),
                .rst  (rst),
                .port (rif[g])
            );
        end
    endgenerate

    // A start is seen as busy only one cycle later
    assign just_started = go_pulse || (auto_apply && (rail_wr != 2'b00));

    always_comb
    begin
        next_trigger    = trigger;
        next_auto_apply = auto_apply;
        next_rate       = rate;
        next_linreg     = linreg;
        next_gaps       = gaps;
        next_blank_cnt  = blank_cnt;
        next_rdata      = rdata;
        // Completion clears the trigger; a new write of one wins
        if (trigger && !just_started && (rail_busy == 2'b00))
        begin
            next_trigger = 1'b0;  // see [R2]
        end
        if (wr_ctrl)
        begin
            next_auto_apply = reg_wdata[pslr_pkg::BIT_AUTO_APPLY];
            next_rate = reg_wdata[pslr_pkg::RATE_LSB +: pslr_pkg::RATE_W];
            if (reg_wdata[pslr_pkg::BIT_TRIGGER])
            begin
                next_trigger = 1'b1;  // see [R1]
            end
        end
        if (wr_linreg)
        begin
            next_linreg = reg_wdata[pslr_pkg::LINREG_LSB +:
                                    pslr_pkg::LINREG_W];
            next_blank_cnt = 18'(BLANK_CYC);  // see [R8]
        end
        else if (blank_cnt != '0)
        begin
            next_blank_cnt = blank_cnt - 18'h00001;
        end
        if (wr_gaps)
        begin
            next_gaps = reg_wdata;  // see [R11]
        end
        if (reg_rd_en)
        begin
            case (reg_addr)
                pslr_pkg::ADDR_RAMP_CTRL:
                begin
                    next_rdata = {trigger, auto_apply, 3'h0, rate};
                end
                pslr_pkg::ADDR_LINREG:
                begin
                    next_rdata = {2'h0, linreg};
                end
                pslr_pkg::ADDR_SEQ_GAPS:
                begin
                    next_rdata = gaps;
                end
                default:
                begin
                    next_rdata = 8'h00;
                end
            endcase
        end
        next_mv = mv_of(linreg);  // see [R9]
        next_gap_cyc = gaps[gap_query_slot] ? 18'(GAP_LONG_CYC)
                                            : 18'(GAP_SHORT_CYC); // see [R10]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trigger    <= pslr_pkg::RST_RAMP_CTRL[pslr_pkg::BIT_TRIGGER];
            auto_apply <= pslr_pkg::RST_RAMP_CTRL[pslr_pkg::BIT_AUTO_APPLY];
            rate       <= pslr_pkg::RST_RAMP_CTRL[2:0];
            linreg     <= pslr_pkg::RST_LINREG[5:0];
            gaps       <= pslr_pkg::RST_SEQ_GAPS;
            blank_cnt  <= '0;
            rdata      <= 8'h00;
            mv         <= 12'h000;
            gap_cyc    <= 18'h00000;
        end
        else
        begin
            trigger    <= next_trigger;
            auto_apply <= next_auto_apply;
            rate       <= next_rate;
            linreg     <= next_linreg;
            gaps       <= next_gaps;
            blank_cnt  <= next_blank_cnt;
            rdata      <= next_rdata;
            mv         <= next_mv;
            gap_cyc    <= next_gap_cyc;
        end
    end

    assign reg_rdata           = rdata;
    assign buck_rail_a_applied = rail_app[0];
    assign buck_rail_b_applied = rail_app[1];
    assign ramp_busy           = |rail_busy;
    assign linear_reg_setpoint = linreg;
    assign linear_reg_mv       = mv;
    assign monitor_blank       = (blank_cnt != '0);  // see [R8]
    assign sequencer_gap_reg   = gaps;
    assign gap_query_cycles    = gap_cyc;

endmodule

/* test/pslr_top_sva.sv */
// Purpose: Port checks for the ramp, regulator and gap registers
// Assumes: Bound to pslr_top
// Notes:   Step checks assume no rate-7 retarget mid-ramp
`timescale 1ns/1ps
module pslr_top_sva
#(
    parameter int unsigned GAP_SHORT_CYC = 4,
    parameter int unsigned GAP_LONG_CYC  = 10
)
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        unlock_ok,
    // Rails and outputs
    input wire logic [5:0]  buck_rail_a_setpoint,
    input wire logic [5:0]  buck_rail_b_setpoint,
    input wire logic [5:0]  buck_rail_a_applied,
    input wire logic [5:0]  buck_rail_b_applied,
    input wire logic        ramp_busy,
    input wire logic [5:0]  linear_reg_setpoint,
    input wire logic [11:0] linear_reg_mv,
    input wire logic        monitor_blank,
    input wire logic [7:0]  sequencer_gap_reg,
    input wire logic [2:0]  gap_query_slot,
    input wire logic [17:0] gap_query_cycles
);
    logic wr_ctrl, wr_lin, wr_gap, sel_long;
    assign wr_ctrl  = reg_wr_en && reg_addr == 8'h1a;
    assign wr_lin   = reg_wr_en && reg_addr == 8'h1b;
    assign wr_gap   = reg_wr_en && reg_addr == 8'h20;
    assign sel_long = sequencer_gap_reg[gap_query_slot];

    function automatic logic [11:0] mv_of(input logic [5:0] c);
        return (c <= 6'h1a) ? 12'(900 + 25 * c) : 12'(1550 + 50 * (c - 6'h1a));
    endfunction

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_rate_immediate: assert property (wr_ctrl && reg_wdata[7]
        && reg_wdata[2:0] == 3'h7 |=> buck_rail_a_applied ==
        $past(buck_rail_a_setpoint) && buck_rail_b_applied ==
        $past(buck_rail_b_setpoint)) else $error("rate 7 not applied");
    a_trigger_busy: assert property (wr_ctrl && reg_wdata[7]
        && reg_wdata[2:0] != 3'h7 && buck_rail_a_setpoint !=
        buck_rail_a_applied |=> ramp_busy) else $error("no ramp start");
    a_step_single: assert property (ramp_busy && $past(ramp_busy)
        |-> buck_rail_a_applied == $past(buck_rail_a_applied)
        || buck_rail_a_applied == $past(buck_rail_a_applied) + 6'h01
        || buck_rail_a_applied == $past(buck_rail_a_applied) - 6'h01)
        else $error("step larger than one code");
    a_dwell_hold: assert property ($changed(buck_rail_a_applied)
        && ramp_busy |=> $stable(buck_rail_a_applied))
        else $error("step without dwell");
    a_blank_write: assert property (wr_lin && unlock_ok |=>
        monitor_blank && linear_reg_setpoint == $past(reg_wdata[5:0]))
        else $error("regulator write not blanked");
    a_locked_hold: assert property ((wr_lin || wr_gap)
        && !unlock_ok |=> $stable(linear_reg_setpoint)
        && $stable(sequencer_gap_reg))
        else $error("locked write accepted");
    a_gap_write: assert property (wr_gap && unlock_ok |=>
        sequencer_gap_reg == $past(reg_wdata))
        else $error("gap write lost");
    a_mv_map: assert property (1'b1 |=>
        linear_reg_mv == mv_of($past(linear_reg_setpoint)))
        else $error("regulator millivolts wrong");
    a_gap_query: assert property (1'b1 |=> gap_query_cycles ==
        ($past(sel_long) ? 18'(GAP_LONG_CYC) : 18'(GAP_SHORT_CYC)))
        else $error("gap time wrong");

    c_trigger: cover property (wr_ctrl && reg_wdata[7]);
    c_ramp_end: cover property ($fell(ramp_busy));
    c_blank: cover property (wr_lin && unlock_ok);
endmodule

bind pslr_top pslr_top_sva #(.GAP_SHORT_CYC(GAP_SHORT_CYC),
    .GAP_LONG_CYC(GAP_LONG_CYC)) u_sva (.clk(clk), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .unlock_ok(unlock_ok), .buck_rail_a_setpoint(buck_rail_a_setpoint),
    .buck_rail_b_setpoint(buck_rail_b_setpoint),
    .buck_rail_a_applied(buck_rail_a_applied),
    .buck_rail_b_applied(buck_rail_b_applied), .ramp_busy(ramp_busy),
    .linear_reg_setpoint(linear_reg_setpoint),
    .linear_reg_mv(linear_reg_mv), .monitor_blank(monitor_blank),
    .sequencer_gap_reg(sequencer_gap_reg),
    .gap_query_slot(gap_query_slot), .gap_query_cycles(gap_query_cycles));

/* test/pslr_host.sv */
// Purpose: Host side of the register port
// Assumes: Requests launched on the falling edge
// Notes:   Write data is scrambled when idle so stale values never pass
`timescale 1ns/1ps
module pslr_host
(
    // Clock
    input  wire logic       clk,
    // Register port
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // Password state
    output logic            unlock_ok
);
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        unlock_ok = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
        @(negedge clk);
        unlock_ok = u;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~d;
        unlock_ok = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask
endmodule

/* test/pslr_top_tb.sv */
// Purpose: Self-checking bench for the ramp and register block
// Assumes: Short counts set through parameters
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
module pslr_top_tb;
    localparam int unsigned DW = 2;
    localparam int unsigned BL = 20;
    localparam int unsigned GS = 4;
    localparam int unsigned GL = 10;
    localparam logic [7:0]  GP = 8'ha5;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] data;
        logic       unl;
        logic [7:0] exp;
    } pslr_row_s;

    logic        clk, rst, wr_en, rd_en, unl, wr_a, wr_b, busy, blank;
    logic [7:0]  addr, wdata, rdata, gaps, rd;
    logic [5:0]  sp_a, sp_b, app_a, app_b, lin;
    logic [11:0] mv;
    logic [2:0]  slot;
    logic [17:0] gcyc;
    int          mismatches = 0;
    int          n_checks = 0;
    int          n;
    pslr_row_s   rows [7] = '{'{8'h1b, 8'h3f, 1'b1, 8'h3f},
        '{8'h1b, 8'h00, 1'b0, 8'h3f}, '{8'h20, 8'h81, 1'b1, 8'h81},
        '{8'h20, 8'hff, 1'b0, 8'h81}, '{8'h1b, 8'hc5, 1'b1, 8'h05},
        '{8'h1a, 8'h3d, 1'b0, 8'h05}, '{8'h33, 8'haa, 1'b1, 8'h00}};
    logic [5:0]  codes [4] = '{6'h00, 6'h1a, 6'h1b, 6'h3f};

    pslr_host host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .unlock_ok(unl));

    pslr_top #(.DWELL_BASE_CYC(DW), .BLANK_CYC(BL), .GAP_SHORT_CYC(GS),
        .GAP_LONG_CYC(GL)) dut (.clk(clk), .rst(rst), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .unlock_ok(unl), .buck_rail_a_setpoint(sp_a),
        .buck_rail_b_setpoint(sp_b), .buck_rail_a_wr(wr_a),
        .buck_rail_b_wr(wr_b), .buck_rail_a_applied(app_a),
        .buck_rail_b_applied(app_b), .ramp_busy(busy),
        .linear_reg_setpoint(lin), .linear_reg_mv(mv),
        .monitor_blank(blank), .sequencer_gap_reg(gaps),
        .gap_query_slot(slot), .gap_query_cycles(gcyc));

    function automatic logic [11:0] exp_mv(input logic [5:0] c);
        return (c <= 6'h1a) ? 12'(900 + 25 * c) : 12'(1550 + 50 * (c - 6'h1a));
    endfunction

    task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results();
    end

    initial
    begin
        rst = 1'b1;
        sp_a = 6'h00;
        sp_b = 6'h00;
        wr_a = 1'b0;
        wr_b = 1'b0;
        slot = 3'h0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i])
        begin
            host.wr(rows[i].addr, rows[i].data, rows[i].unl);
            host.rd(rows[i].addr, rd);
            chk(18'(rd), 18'(rows[i].exp), "row");
        end
        // Reset in mid-run must restore every register
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        host.rd(8'h1a, rd);
        chk(18'(rd), 18'h06, "ctrl reset");
        host.rd(8'h1b, rd);
        chk(18'(rd), 18'h1f, "code reset");
        host.rd(8'h20, rd);
        chk(18'(rd), 18'h00, "gap reset");
        chk(18'(mv), 18'h708, "mv reset");
        for (int r = 0; r < 8; r++)
        begin
            sp_a = (r % 2 == 0) ? 6'h01 : 6'h00;
            host.wr(8'h1a, 8'h80 | 8'(r), 1'b0);
            n = 0;
            while (app_a !== sp_a && n < 300)
            begin
                @(negedge clk);
                n++;
            end
            chk(18'(n), 18'(r < 7 ? DW << (6 - r) : 0),
                "dwell");
        end
        sp_a = 6'h03;
        sp_b = 6'h02;
        host.wr(8'h1a, 8'h86, 1'b0);
        host.rd(8'h1a, rd);
        chk(18'(rd[7]), 18'h1, "trigger pending");
        // The read above already spanned two ramp cycles
        n = 2;
        while (busy !== 1'b0 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk(18'(n), 18'(3 * DW), "ramp span");
        chk(18'(app_b), 18'h02, "rail b");
        host.rd(8'h1a, rd);
        chk(18'(rd), 18'h06, "trigger clear");
        host.wr(8'h1a, 8'h46, 1'b0);
        sp_b = 6'h00;
        @(negedge clk);
        wr_b = 1'b1;
        @(negedge clk);
        wr_b = 1'b0;
        n = 0;
        while (app_b !== 6'h00 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk(18'(n), 18'(2 * DW), "auto ramp");
        chk(18'(app_a), 18'h03, "other rail");
        host.wr(8'h1a, 8'h06, 1'b0);
        sp_a = 6'h00;
        @(negedge clk);
        wr_a = 1'b1;
        @(negedge clk);
        wr_a = 1'b0;
        repeat (20) @(negedge clk);
        chk(18'(app_a), 18'h03, "held for trigger");
        foreach (codes[i])
        begin
            host.wr(8'h1b, {2'b00, codes[i]}, 1'b1);
            n = 0;
            while (blank === 1'b1 && n < 100)
            begin
                @(negedge clk);
                n++;
            end
            chk(18'(n), 18'(BL), "blank span");
            chk(18'(mv), 18'(exp_mv(codes[i])), "mv");
            chk(18'(lin), 18'(codes[i]), "code");
        end
        host.wr(8'h1b, 8'h3f, 1'b0);
        chk(18'(blank), 18'h0, "locked blank");
        host.wr(8'h20, GP, 1'b1);
        chk(18'(gaps), 18'(GP), "gap reg");
        for (int s = 0; s < 8; s++)
        begin
            @(negedge clk);
            slot = 3'(s);
            @(negedge clk);
            chk(gcyc, 18'(GP[s] ? GL : GS), "gap");
        end
        results();
    end
endmodule
